// ---- bench/tb_top.sv ----
// tb_top: self-checking bench for the sleep and clock gating block.
// assumes a classic wishbone slave that acks one cycle after taking a request.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, wb_dat_o;
  logic wb_ack_o, core_halt_o, sleep_instr = 1'b0, wake = 1'b0, fuse = 1'b0, iref = 1'b0;
  logic conv_on = 1'b0, wd_on = 1'b1;
  logic [6:0] acc_i = 7'h7f, clk_en, acc_o;
  logic io_en, conv_en, osc_en, buf_en, comp_en, wd_run, conv_ext;
  logic [7:0] q;
  int failures = 0, samples_checked = 0;
  always #10 clk_i = ~clk_i;
  spcg_sleep_gate i_spcg_sleep_gate (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sleep_instr_i(sleep_instr), .wake_event_i(wake),
    .core_halt_o(core_halt_o), .debug_enable_fuse_i(fuse), .converter_enabled_i(conv_on),
    .watchdog_enabled_i(wd_on), .comparator_int_ref_i(iref), .periph_access_i(acc_i),
    .periph_clk_en_o(clk_en), .periph_access_o(acc_o), .io_clk_en_o(io_en),
    .converter_clk_en_o(conv_en), .main_osc_en_o(osc_en), .input_buffer_en_o(buf_en),
    .comparator_en_o(comp_en), .watchdog_run_o(wd_run), .converter_extended_o(conv_ext));
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one classic cycle, entered right after a rising edge; ends one idle cycle later
  task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; dat <= {24'h0, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk_i);
    end
    q = wb_dat_o[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n == 50)
    begin
      failures++;
      $display("[ERR] ack expected 1 seen 0");
      final_report();
    end
    @(posedge clk_i);
  endtask
  // sleep in one mode and measure the halt that follows a wake event
  task automatic nap(input logic [1:0] m, input int len, input logic [6:0] ck);
    int n;
    wb(spcg_pkg::ADDR_SLEEP_CONTROL, 1'b1, {1'b0, m, 5'h10});
    sleep_instr <= 1'b1;
    @(posedge clk_i);
    sleep_instr <= 1'b0;
    #1;
    chk("halt", 8'h01, {7'h0, core_halt_o});
    chk("io_clk", {7'h0, m == 2'b00}, {7'h0, io_en});
    chk("conv_clk", {7'h0, m[1] == 1'b0}, {7'h0, conv_en});
    chk("osc", {7'h0, m != 2'b10 || fuse}, {7'h0, osc_en});
    chk("in_buf", {7'h0, !m[1]}, {7'h0, buf_en});
    chk("comp", {7'h0, !m[1] || iref}, {7'h0, comp_en});
    chk("wdog", {7'h0, wd_on}, {7'h0, wd_run});
    if (m == 2'b00) chk("idle_gate", {1'b0, ck}, {1'b0, clk_en});
    wb(spcg_pkg::ADDR_STATUS, 1'b0, 8'h00); chk("status_sleep", 8'h05, q);
    @(posedge clk_i);
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    n = 0;
    #1;
    while (core_halt_o === 1'b1 && n < 100)
    begin
      n++;
      @(posedge clk_i);
      #1;
    end
    chk("halt_len", len[7:0], n[7:0]);
    @(posedge clk_i);
    wb(spcg_pkg::ADDR_SLEEP_CONTROL, 1'b1, 8'h00);
  endtask
  // ------------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(spcg_pkg::ADDR_SLEEP_CONTROL, 1'b0, 8'h00); chk("sc_rst", 8'h00, q);
    wb(spcg_pkg::ADDR_PERIPH_GATE, 1'b0, 8'h00); chk("gate_rst", 8'h00, q);
    chk("clk_rst", 8'h7f, {1'b0, clk_en});
    wb(spcg_pkg::ADDR_STATUS, 1'b0, 8'h00); chk("status_rst", 8'h08, q);
    $display("test reset done");
    wb(spcg_pkg::ADDR_SLEEP_CONTROL, 1'b1, 8'hef);
    wb(spcg_pkg::ADDR_SLEEP_CONTROL, 1'b0, 8'h00); chk("sc_rsvd", 8'h60, q);
    wb(spcg_pkg::ADDR_PERIPH_GATE, 1'b1, 8'hff);
    wb(spcg_pkg::ADDR_PERIPH_GATE, 1'b0, 8'h00); chk("gate_rsvd", 8'h7f, q);
    wb(4'hc, 1'b1, 8'h00);
    wb(4'hc, 1'b0, 8'h00); chk("unmapped", 8'h00, q);
    wb(spcg_pkg::ADDR_PERIPH_GATE, 1'b0, 8'h00); chk("gate_kept", 8'h7f, q);
    for (int b = 0; b < 7; b++)
    begin
      wb(spcg_pkg::ADDR_PERIPH_GATE, 1'b1, 8'h01 << b);
      #1;
      chk("clk_en", ~(8'h81 << b) & 8'h7f, {1'b0, clk_en});
      chk("access", ~(8'h81 << b) & 8'h7f, {1'b0, acc_o});
      chk("comp_gate", {7'h0, b != 0}, {7'h0, comp_en});
      @(posedge clk_i);
    end
    wb(spcg_pkg::ADDR_PERIPH_GATE, 1'b1, 8'h00);
    #1;
    chk("ungate", 8'h7f, {1'b0, clk_en});
    @(posedge clk_i);
    conv_on <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk("ext_clear", 8'h00, {7'h0, conv_ext});
    @(posedge clk_i);
    conv_on <= 1'b0;
    @(posedge clk_i);
    conv_on <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("ext_set", 8'h01, {7'h0, conv_ext});
    @(posedge clk_i);
    conv_on <= 1'b0;
    $display("test gating done");
    wb(spcg_pkg::ADDR_SLEEP_CONTROL, 1'b1, 8'h40);
    sleep_instr <= 1'b1;
    @(posedge clk_i);
    sleep_instr <= 1'b0;
    #1;
    chk("no_arm", 8'h00, {7'h0, core_halt_o});
    @(posedge clk_i);
    wb(spcg_pkg::ADDR_PERIPH_GATE, 1'b1, 8'h10);
    nap(2'b00, 4, 7'h6f);
    nap(2'b01, 54, 7'h6f);
    nap(2'b10, 54, 7'h6f);
    iref <= 1'b1;
    nap(2'b11, 6, 7'h6f);
    fuse <= 1'b1;
    wd_on <= 1'b0;
    nap(2'b10, 54, 7'h6f);
    $display("test sleep done");
    wb(spcg_pkg::ADDR_SLEEP_CONTROL, 1'b1, 8'h70);
    wb(spcg_pkg::ADDR_PERIPH_GATE, 1'b1, 8'h55);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(spcg_pkg::ADDR_SLEEP_CONTROL, 1'b0, 8'h00); chk("sc_rerst", 8'h00, q);
    wb(spcg_pkg::ADDR_PERIPH_GATE, 1'b0, 8'h00); chk("gate_rerst", 8'h00, q);
    wb(spcg_pkg::ADDR_STATUS, 1'b0, 8'h00); chk("status_rerst", 8'h08, q);
    chk("clk_rerst", 8'h7f, {1'b0, clk_en});
    $display("test reset again done");
    final_report();
  end
endmodule // tb_top
`default_nettype wire

// ---- src/spcg_pkg.sv ----
// spcg_pkg: register map, field positions, reset values and timing counts
// for the sleep and peripheral clock gating block.
// assumes a 50 MHz system clock and a 32-bit classic wishbone slave port.

package spcg_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_SLEEP_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_PERIPH_GATE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  // sleep control fields
  localparam int SLEEP_ARM_BIT = 4;
  localparam int SLEEP_MODE_LSB = 5;
  localparam logic [7:0] SLEEP_CONTROL_MASK = 8'h70;

  // gate register fields
  localparam int GATE_CONVERTER = 0;
  localparam int GATE_SERIAL_ZERO = 1;
  localparam int GATE_SERIAL_ONE = 2;
  localparam int GATE_UNIVERSAL = 3;
  localparam int GATE_TIMER_ZERO = 4;
  localparam int GATE_TIMER_ONE = 5;
  localparam int GATE_TWO_WIRE = 6;
  localparam logic [7:0] PERIPH_GATE_MASK = 8'h7f;

  // values after reset
  localparam logic [7:0] SLEEP_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PERIPH_GATE_RESET = 8'h00;

  // sleep modes
  typedef enum logic [1:0] {
    SPCG_MODE_IDLE = 2'b00,
    SPCG_MODE_NOISE = 2'b01,
    SPCG_MODE_POWER_DOWN = 2'b10,
    SPCG_MODE_STANDBY = 2'b11
  } spcg_mode_e;

  // sleep sequencer states
  typedef enum logic [1:0] {
    SPCG_ST_ACTIVE = 2'b00,
    SPCG_ST_ASLEEP = 2'b01,
    SPCG_ST_WAKE = 2'b10
  } spcg_state_e;

  // timing
  localparam int WAKE_HALT_CYCLES = 4;
  localparam int STANDBY_WAKE_CYCLES = 6;
  localparam int STARTUP_NS = 1000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] WAKE_CNT_RESET = 8'h00;

endpackage

// ---- src/spcg_sleep_gate.sv ----
// spcg_sleep_gate: sleep control and per-peripheral clock gating.
// assumes a core that pulses sleep_instr_i on a sleep instruction and
// wake_event_i on an enabled interrupt; all inputs are on clk_i.
`timescale 1ns/1ps
`default_nettype none

module spcg_sleep_gate
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core side
  input wire logic sleep_instr_i,
  input wire logic wake_event_i,
  output logic core_halt_o,
  // fuses and peripheral state
  input wire logic debug_enable_fuse_i,
  input wire logic converter_enabled_i,
  input wire logic watchdog_enabled_i,
  input wire logic comparator_int_ref_i,
  input wire logic [6:0] periph_access_i,
  // clock enables and controls
  output logic [6:0] periph_clk_en_o,
  output logic [6:0] periph_access_o,
  output logic io_clk_en_o,
  output logic converter_clk_en_o,
  output logic main_osc_en_o,
  output logic input_buffer_en_o,
  output logic comparator_en_o,
  output logic watchdog_run_o,
  output logic converter_extended_o
);

  // ------------------------------------------------------------------
  // register file
  // ------------------------------------------------------------------
  logic [7:0] sleep_control;
  logic [7:0] peripheral_clock_gate;
  spcg_pkg::spcg_state_e state;
  logic [7:0] wake_cnt;
  logic converter_was_on;
  logic converter_extended;
  logic ack;

  logic wb_req;
  logic wb_wr;
  // ack in the request term keeps a held strobe from being taken twice;
  // the price is one idle cycle between back-to-back transfers
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack;
  assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];

  // one registered ack per request, a cycle after it, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack <= 1'b0;
    else
      ack <= wb_req;
  end
  assign wb_ack_o = ack;

  // writable bits only; reserved bits never store
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sleep_control <= spcg_pkg::SLEEP_CONTROL_RESET;
      peripheral_clock_gate <= spcg_pkg::PERIPH_GATE_RESET;
    end
    else if (wb_wr)
    begin
      if (wb_adr_i == spcg_pkg::ADDR_SLEEP_CONTROL)
        sleep_control <= wb_dat_i[7:0] & spcg_pkg::SLEEP_CONTROL_MASK;
      if (wb_adr_i == spcg_pkg::ADDR_PERIPH_GATE)
        peripheral_clock_gate <= wb_dat_i[7:0] & spcg_pkg::PERIPH_GATE_MASK;
    end
  end

  // read data registered; unmapped offsets read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h00000000;
    else if (wb_req)
    begin
      case (wb_adr_i)
        spcg_pkg::ADDR_SLEEP_CONTROL: wb_dat_o <= {24'h000000, sleep_control};
        spcg_pkg::ADDR_PERIPH_GATE: wb_dat_o <= {24'h000000, peripheral_clock_gate};
        spcg_pkg::ADDR_STATUS: wb_dat_o <= {28'h0000000, converter_extended,
          core_halt_o, state};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // sleep sequencer
  // ------------------------------------------------------------------
  spcg_pkg::spcg_mode_e mode;
  logic sleep_arm;
  logic [7:0] wake_len;
  assign mode = spcg_pkg::spcg_mode_e'(sleep_control[spcg_pkg::SLEEP_MODE_LSB +: 2]);
  assign sleep_arm = sleep_control[spcg_pkg::SLEEP_ARM_BIT];

  // power-down and standby stop both the io and the converter clocks
  function automatic logic all_clocks_stop(input spcg_pkg::spcg_mode_e m);
    return (m == spcg_pkg::SPCG_MODE_POWER_DOWN) || (m == spcg_pkg::SPCG_MODE_STANDBY);
  endfunction

  // standby keeps the oscillator so skips start-up; idle pays the halt only;
  // noise and power-down pay start-up plus the halt; a fixed start-up figure is a simplification
  always_comb
  begin
    if (mode == spcg_pkg::SPCG_MODE_STANDBY)
      wake_len = 8'(spcg_pkg::STANDBY_WAKE_CYCLES);
    else if (mode == spcg_pkg::SPCG_MODE_IDLE)
      wake_len = 8'(spcg_pkg::WAKE_HALT_CYCLES);
    else
      wake_len = 8'(spcg_pkg::STARTUP_CYCLES + spcg_pkg::WAKE_HALT_CYCLES);
  end

  // the wake counter is loaded on the wake event and runs down to one;
  // the mode is read live, so software must not change it while asleep
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= spcg_pkg::SPCG_ST_ACTIVE;
      wake_cnt <= spcg_pkg::WAKE_CNT_RESET;
    end
    else
    begin
      case (state)
        spcg_pkg::SPCG_ST_ACTIVE:
          if (sleep_instr_i && sleep_arm)
            state <= spcg_pkg::SPCG_ST_ASLEEP;
        spcg_pkg::SPCG_ST_ASLEEP:
          if (wake_event_i)
          begin
            state <= spcg_pkg::SPCG_ST_WAKE;
            wake_cnt <= wake_len;
          end
        spcg_pkg::SPCG_ST_WAKE:
          if (wake_cnt <= 8'h01)
          begin
            state <= spcg_pkg::SPCG_ST_ACTIVE;
            wake_cnt <= spcg_pkg::WAKE_CNT_RESET;
          end
          else
            wake_cnt <= wake_cnt - 8'h01;
        default:
          state <= spcg_pkg::SPCG_ST_ACTIVE;
      endcase
    end
  end

  logic asleep;
  logic deep;
  logic clocks_stopped;
  assign asleep = (state == spcg_pkg::SPCG_ST_ASLEEP);
  assign deep = asleep && (mode != spcg_pkg::SPCG_MODE_IDLE);
  // both io and converter clocks are off here, so buffers drop as well
  assign clocks_stopped = asleep && all_clocks_stop(mode);
  assign core_halt_o = (state != spcg_pkg::SPCG_ST_ACTIVE);

  // ------------------------------------------------------------------
  // clock enables
  // ------------------------------------------------------------------
  // io clock runs in active, wake and idle only
  assign io_clk_en_o = !deep;
  assign converter_clk_en_o = !clocks_stopped
    && !peripheral_clock_gate[spcg_pkg::GATE_CONVERTER];
  assign main_osc_en_o = !(asleep && mode == spcg_pkg::SPCG_MODE_POWER_DOWN)
    || debug_enable_fuse_i;
  // digital inputs kept only for wake detection, handled outside
  // wake pins keep their buffers through a separate path not modelled here
  assign input_buffer_en_o = !clocks_stopped;
  assign watchdog_run_o = watchdog_enabled_i;

  // freezing by clock enable keeps every flop and allocation of the unit
  always_comb
  begin
    periph_clk_en_o = ~peripheral_clock_gate[6:0] & {7{io_clk_en_o}};
    periph_clk_en_o[spcg_pkg::GATE_CONVERTER] = converter_clk_en_o;
  end

  // register strobes do not reach a gated unit
  assign periph_access_o = periph_access_i & ~peripheral_clock_gate[6:0];

  // comparator needs the converter gate bit clear; power-down and standby drop it unless on reference
  assign comparator_en_o = !peripheral_clock_gate[spcg_pkg::GATE_CONVERTER]
    && (input_buffer_en_o || comparator_int_ref_i);

  // converter enable is never forced off by sleep; track off-on cycles
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      converter_was_on <= 1'b0;
      converter_extended <= 1'b1;
    end
    else
    begin
      converter_was_on <= converter_enabled_i;
      if (converter_enabled_i && !converter_was_on)
        converter_extended <= 1'b1;
      else if (converter_enabled_i && converter_clk_en_o)
        converter_extended <= 1'b0;
    end
  end
  assign converter_extended_o = converter_extended;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  sequence armed_sleep_s;
    state == spcg_pkg::SPCG_ST_ACTIVE && sleep_instr_i && sleep_arm;
  endsequence

  sequence idle_wake_s;
    asleep && wake_event_i && mode == spcg_pkg::SPCG_MODE_IDLE;
  endsequence

  sequence standby_wake_s;
    asleep && wake_event_i && mode == spcg_pkg::SPCG_MODE_STANDBY;
  endsequence

  // ------------------------------------------------------------------
  // bus and register checks
  // ------------------------------------------------------------------
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  gate_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_wr && wb_adr_i == spcg_pkg::ADDR_PERIPH_GATE
    |=> peripheral_clock_gate == ($past(wb_dat_i[7:0]) & spcg_pkg::PERIPH_GATE_MASK))
    else $error("gate write did not land");
  mode_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_wr && wb_adr_i == spcg_pkg::ADDR_SLEEP_CONTROL
    |=> sleep_control == ($past(wb_dat_i[7:0]) & spcg_pkg::SLEEP_CONTROL_MASK))
    else $error("sleep control write did not land");

  // ------------------------------------------------------------------
  // gating checks
  // ------------------------------------------------------------------
  idle_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !deep |-> periph_clk_en_o[6:1] == ~peripheral_clock_gate[6:1])
    else $error("gate bits not applied while awake");
  two_wire_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    peripheral_clock_gate[spcg_pkg::GATE_TWO_WIRE] |-> !periph_clk_en_o[spcg_pkg::GATE_TWO_WIRE])
    else $error("gated two-wire unit still clocked");
  timer_zero_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    peripheral_clock_gate[spcg_pkg::GATE_TIMER_ZERO]
    |-> !periph_clk_en_o[spcg_pkg::GATE_TIMER_ZERO])
    else $error("gated timer zero still clocked");
  universal_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    peripheral_clock_gate[spcg_pkg::GATE_UNIVERSAL] |-> !periph_clk_en_o[spcg_pkg::GATE_UNIVERSAL])
    else $error("gated serial unit still clocked");
  serial_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (peripheral_clock_gate[2:1] & periph_clk_en_o[2:1]) == 2'b00)
    else $error("gated serial port still clocked");
  conv_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    peripheral_clock_gate[spcg_pkg::GATE_CONVERTER] |-> !converter_clk_en_o && !comparator_en_o)
    else $error("gated converter or comparator still on");
  ungate_resume_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(peripheral_clock_gate[spcg_pkg::GATE_TIMER_ONE]) && !deep
    |-> periph_clk_en_o[spcg_pkg::GATE_TIMER_ONE])
    else $error("ungated timer not restarted");

  // ------------------------------------------------------------------
  // sleep checks
  // ------------------------------------------------------------------
  asleep_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    asleep && !wake_event_i |=> asleep)
    else $error("sleep left without wake event");
  wake_enter_a: assert property (@(posedge clk_i) disable iff (rst_i)
    asleep && wake_event_i |=> state == spcg_pkg::SPCG_ST_WAKE && core_halt_o)
    else $error("wake event did not start wake count");
  io_active_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !asleep |-> io_clk_en_o && input_buffer_en_o)
    else $error("io clock or buffers off while awake");
  deep_buffer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    asleep && all_clocks_stop(mode) |-> !input_buffer_en_o && !converter_clk_en_o)
    else $error("buffers or converter clock on in deep sleep");
  noise_conv_a: assert property (@(posedge clk_i) disable iff (rst_i)
    asleep && mode == spcg_pkg::SPCG_MODE_NOISE && !peripheral_clock_gate[0]
    |-> converter_clk_en_o)
    else $error("converter clock off in noise reduction");
  standby_osc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    asleep && mode == spcg_pkg::SPCG_MODE_STANDBY |-> main_osc_en_o)
    else $error("oscillator stopped in standby");
  powerdown_osc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    asleep && mode == spcg_pkg::SPCG_MODE_POWER_DOWN && !debug_enable_fuse_i |-> !main_osc_en_o)
    else $error("oscillator runs in power-down");
  osc_active_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !asleep |-> main_osc_en_o)
    else $error("oscillator stopped while awake");
  comp_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    comparator_int_ref_i && !peripheral_clock_gate[0] |-> comparator_en_o)
    else $error("comparator on reference dropped");
  watchdog_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    watchdog_enabled_i |-> watchdog_run_o)
    else $error("enabled watchdog stopped");
  conv_extend_a: assert property (@(posedge clk_i) disable iff (rst_i)
    converter_enabled_i && !converter_was_on |=> converter_extended_o)
    else $error("re-enabled converter not extended");

  sleep_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    armed_sleep_s |=> state == spcg_pkg::SPCG_ST_ASLEEP)
    else $error("armed sleep not entered");
  no_arm_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == spcg_pkg::SPCG_ST_ACTIVE && !sleep_arm |=> state == spcg_pkg::SPCG_ST_ACTIVE)
    else $error("sleep entered without arm");
  gate_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    peripheral_clock_gate[spcg_pkg::GATE_TIMER_ONE] |-> !periph_clk_en_o[spcg_pkg::GATE_TIMER_ONE])
    else $error("gated timer still clocked");
  gate_access_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (periph_access_o & peripheral_clock_gate[6:0]) == 7'h00)
    else $error("access to gated unit");
  deep_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    deep |-> periph_clk_en_o[6:1] == 6'h00)
    else $error("clock runs in deep sleep");
  reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleep_control & ~spcg_pkg::SLEEP_CONTROL_MASK) == 8'h00)
    else $error("reserved sleep bits set");
  gate_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !peripheral_clock_gate[7])
    else $error("reserved gate bit set");
  standby_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    standby_wake_s |=> core_halt_o [*6] ##1 !core_halt_o)
    else $error("standby wake not six cycles");
  idle_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    idle_wake_s |=> core_halt_o [*4] ##1 !core_halt_o)
    else $error("idle wake halt not four cycles");
  debug_osc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    debug_enable_fuse_i |-> main_osc_en_o)
    else $error("oscillator stopped with debug fuse");
  comp_ref_a: assert property (@(posedge clk_i) disable iff (rst_i)
    deep && mode != spcg_pkg::SPCG_MODE_NOISE && !comparator_int_ref_i |-> !comparator_en_o)
    else $error("comparator on in deep sleep");
  reset_clear_a: assert property (@(posedge clk_i)
    rst_i |=> sleep_control == 8'h00 && peripheral_clock_gate == 8'h00)
    else $error("registers not cleared by reset");

endmodule // spcg_sleep_gate

`default_nettype wire
